// file: rtl/sid_pkg.sv
// Package for the split isochronous descriptor engine: field layouts,
// status bit positions and state codes.
// Assumes one 20 MHz clock domain shared by every user of these types.
package sid_pkg;

    localparam int STAT_ACTIVE = 7;
    localparam int STAT_ERR_HS = 6;
    localparam int STAT_BUF_ERR = 5;
    localparam int STAT_BABBLE = 4;
    localparam int STAT_XACT_ERR = 3;
    localparam int STAT_MISSED = 2;
    localparam int STAT_SPLIT = 1;

    localparam logic [1:0] TPOS_ALL = 2'h0;
    localparam logic [1:0] TPOS_BEGIN = 2'h1;
    localparam logic [1:0] TPOS_MID = 2'h2;
    localparam logic [1:0] TPOS_END = 2'h3;

    localparam logic [2:0] SS_COUNT_ONE = 3'h1;
    localparam logic [11:0] OFFSET_LAST = 12'hfff;

    // Second half of the descriptor plus the first-half fields it needs
    typedef struct packed {
        logic dir_in;
        logic [7:0] start_split_mask;
        logic [7:0] complete_split_mask;
        logic [9:0] total_byte_count;
        logic [7:0] complete_split_progress_mask;
        logic [7:0] descriptor_status_byte;
        logic [19:0] buffer_page_pointer0;
        logic [19:0] buffer_page_pointer1;
        logic page_select;
        logic [11:0] current_buffer_offset;
        logic [1:0] transaction_position;
        logic [2:0] start_split_count;
        logic [26:0] back_link_pointer;
    } sid_desc_s;

    // Outcome of one split transaction reported by the link logic
    typedef struct packed {
        logic ok;
        logic last;
        logic err_handshake;
        logic buffer_error;
        logic babble;
        logic xact_error;
    } sid_res_s;

    typedef struct packed {
        logic [31:0] addr;
        logic [7:0] data;
    } sid_ent_s;

    typedef enum logic [3:0] {
        SID_IDLE = 4'h1,
        SID_WAIT = 4'h2,
        SID_BUSY = 4'h4,
        SID_DONE = 4'h8
    } sid_state_e;

    typedef struct packed {
        sid_state_e fsm;
        sid_desc_s d;
        logic out_v;
        sid_ent_s out_e;
        logic sk_v;
        sid_ent_s sk_e;
        logic in_ready;
        logic ss_req;
        logic cs_req;
        logic [1:0] tpos;
        logic wb_valid;
    } sid_st_s;

endpackage : sid_pkg

// file: rtl/sid_engine.sv
// Split isochronous descriptor engine: runs start-splits and
// complete-splits for one descriptor and writes its status back.
// Assumes the link logic and memory port share clk; uframe_tick is a
// one-cycle pulse from the frame timer on the same clock.
//
// How it works
// - Each executed complete-split sets its microframe bit in the progress mask.
// - An ERR handshake from the translator sets status bit 6.
// - A buffer overrun or underrun sets status bit 5.
// - Detected babble sets status bit 4.
// - A transaction error on the split sets status bit 3.
// - A complete-split still unanswered at the next microframe tick sets status bit 2.
// - Status bit 1 holds the split state, zero for start, one for complete.
// - Page pointers are 4K aligned and the offset advances with each byte taken while the byte count is nonzero.
// - The data address joins the selected page pointer and the offset.
// - Complete-splits run only in microframes set in the complete-split mask.
module sid_engine (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Descriptor load and write-back
    input wire logic load_valid,
    input wire sid_pkg::sid_desc_s load_desc,
    output sid_pkg::sid_desc_s wb_desc,
    output logic wb_valid,
    // Microframe timing
    input wire logic uframe_tick,
    input wire logic [2:0] uframe_index,
    // Split requests and results
    output logic ss_req,
    output logic cs_req,
    output logic [1:0] ss_position,
    input wire logic res_valid,
    input wire sid_pkg::sid_res_s res,
    // Data stream in
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    output logic in_ready,
    // Data stream to memory
    output logic mem_valid,
    output logic [31:0] mem_addr,
    output logic [7:0] mem_data,
    input wire logic mem_ready
);

    ////////////////////////////////////////////////////////////////////////////

    sid_pkg::sid_st_s st;
    sid_pkg::sid_st_s next_st;

    // Selected page joined with the current offset
    function automatic logic [31:0] data_addr(input sid_pkg::sid_desc_s d);
        logic [19:0] page;
        page = d.page_select ? d.buffer_page_pointer1 : d.buffer_page_pointer0;
        return {page, d.current_buffer_offset};
    endfunction : data_addr

    function automatic logic is_active(input sid_pkg::sid_desc_s d);
        return d.descriptor_status_byte[sid_pkg::STAT_ACTIVE];
    endfunction : is_active

    ////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        logic take;
        logic pop;
        logic finish;
        logic split_cs;
        take = in_valid && st.in_ready;
        pop = st.out_v && mem_ready;
        finish = 1'b0;
        split_cs = st.d.descriptor_status_byte[sid_pkg::STAT_SPLIT];
        next_st = st;
        next_st.ss_req = 1'b0;
        next_st.cs_req = 1'b0;
        next_st.wb_valid = 1'b0;

        // Two-entry buffer: a memory stall parks one word, then in_ready drops
        if (!st.out_v || pop)
        begin
            if (st.sk_v)
            begin
                next_st.out_e = st.sk_e;
                next_st.sk_v = 1'b0;
            end
            else if (take)
            begin
                next_st.out_v = 1'b1;
                next_st.out_e = '{addr: data_addr(st.d), data: in_data};
            end
            else
            begin
                next_st.out_v = 1'b0;
            end
        end
        else if (take)
        begin
            next_st.sk_v = 1'b1;
            next_st.sk_e = '{addr: data_addr(st.d), data: in_data};
        end

        if (take)
        begin
            if (st.d.total_byte_count == '0)
            begin
                // More data than the descriptor allows
                next_st.d.descriptor_status_byte[sid_pkg::STAT_BUF_ERR] = 1'b1;
                finish = 1'b1;
            end
            else
            begin
                next_st.d.total_byte_count = st.d.total_byte_count - 10'h1;
                next_st.d.current_buffer_offset = st.d.current_buffer_offset + 12'h1;
                if (st.d.current_buffer_offset == sid_pkg::OFFSET_LAST)
                begin
                    next_st.d.page_select = 1'b1;
                end
            end
        end

        unique case (st.fsm)
            sid_pkg::SID_IDLE:
            begin
                if (load_valid && is_active(load_desc))
                begin
                    next_st.d = load_desc;
                    next_st.tpos = load_desc.transaction_position;
                    next_st.fsm = sid_pkg::SID_WAIT;
                end
            end
            sid_pkg::SID_WAIT:
            begin
                if (uframe_tick)
                begin
                    if (!split_cs && st.d.start_split_mask[uframe_index])
                    begin
                        next_st.ss_req = 1'b1;
                        next_st.fsm = sid_pkg::SID_BUSY;
                    end
                    else if (split_cs && st.d.complete_split_mask[uframe_index])
                    begin
                        next_st.cs_req = 1'b1;
                        next_st.d.complete_split_progress_mask[uframe_index] = 1'b1;
                        next_st.fsm = sid_pkg::SID_BUSY;
                    end
                end
            end
            sid_pkg::SID_BUSY:
            begin
                if (uframe_tick && split_cs)
                begin
                    // Microframe ended with the complete-split still unanswered
                    next_st.d.descriptor_status_byte[sid_pkg::STAT_MISSED] = 1'b1;
                    finish = 1'b1;
                end
                else if (res_valid)
                begin
                    if (res.err_handshake)
                    begin
                        next_st.d.descriptor_status_byte[sid_pkg::STAT_ERR_HS] = 1'b1;
                    end
                    if (res.buffer_error)
                    begin
                        next_st.d.descriptor_status_byte[sid_pkg::STAT_BUF_ERR] = 1'b1;
                    end
                    if (res.babble)
                    begin
                        next_st.d.descriptor_status_byte[sid_pkg::STAT_BABBLE] = 1'b1;
                    end
                    if (res.xact_error)
                    begin
                        next_st.d.descriptor_status_byte[sid_pkg::STAT_XACT_ERR] = 1'b1;
                    end
                    next_st.fsm = sid_pkg::SID_WAIT;
                    if (!res.ok || res.err_handshake || res.buffer_error || res.babble
                        || res.xact_error)
                    begin
                        finish = 1'b1;
                    end
                    else if (split_cs)
                    begin
                        finish = res.last;
                    end
                    else if (!st.d.dir_in && st.d.start_split_count > sid_pkg::SS_COUNT_ONE)
                    begin
                        // More OUT start-splits to go for this payload
                        next_st.d.start_split_count = st.d.start_split_count - 3'h1;
                        next_st.tpos = (st.d.start_split_count == 3'h2) ?
                            sid_pkg::TPOS_END : sid_pkg::TPOS_MID;
                    end
                    else
                    begin
                        if (!st.d.dir_in)
                        begin
                            next_st.d.start_split_count = '0;
                        end
                        if (st.d.complete_split_mask == '0)
                        begin
                            finish = 1'b1;
                        end
                        else
                        begin
                            next_st.d.descriptor_status_byte[sid_pkg::STAT_SPLIT] = 1'b1;
                        end
                    end
                end
            end
            sid_pkg::SID_DONE:
            begin
                // Hold until the buffer drains so write-back covers all data
                if (!next_st.out_v && !next_st.sk_v)
                begin
                    next_st.wb_valid = 1'b1;
                    next_st.fsm = sid_pkg::SID_IDLE;
                end
            end
            default:
            begin
                next_st.fsm = sid_pkg::SID_IDLE;
            end
        endcase

        if (finish)
        begin
            next_st.d.descriptor_status_byte[sid_pkg::STAT_ACTIVE] = 1'b0;
            next_st.d.descriptor_status_byte[sid_pkg::STAT_SPLIT] = 1'b0;
            next_st.fsm = sid_pkg::SID_DONE;
        end
        next_st.d.transaction_position = next_st.tpos;
        next_st.in_ready = !next_st.sk_v && is_active(next_st.d)
            && next_st.fsm != sid_pkg::SID_IDLE;
    end

    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= '0;
            st.fsm <= sid_pkg::SID_IDLE;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign wb_desc = st.d;
    assign wb_valid = st.wb_valid;
    assign ss_req = st.ss_req;
    assign cs_req = st.cs_req;
    assign ss_position = st.tpos;
    assign in_ready = st.in_ready;
    assign mem_valid = st.out_v;
    assign mem_addr = st.out_e.addr;
    assign mem_data = st.out_e.data;

endmodule : sid_engine

// file: bench/sid_props.sv
// Port checker for the split descriptor engine.
// Assumes one clock domain; the bind below attaches it to every engine.
module sid_props (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Engine ports
    input wire logic uframe_tick,
    input wire logic [2:0] uframe_index,
    input wire logic ss_req,
    input wire logic cs_req,
    input wire logic res_valid,
    input wire sid_pkg::sid_res_s res,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire sid_pkg::sid_desc_s wb_desc,
    input wire logic wb_valid,
    input wire logic mem_valid,
    input wire logic [31:0] mem_addr,
    input wire logic mem_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic pend;
    logic pend_cs;
    logic [7:0] st;
    logic [31:0] sel;
    assign st = wb_desc.descriptor_status_byte;
    assign sel = {wb_desc.page_select ? wb_desc.buffer_page_pointer1 :
        wb_desc.buffer_page_pointer0, wb_desc.current_buffer_offset};
    // A split stays open until answered or the descriptor is written back
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
        begin
            pend <= 1'b0;
            pend_cs <= 1'b0;
        end
        else
        begin
            pend <= ss_req | cs_req | (pend & ~res_valid & ~wb_valid);
            pend_cs <= cs_req | (pend_cs & ~res_valid & ~wb_valid);
        end
    sequence take_s;
        in_valid && in_ready && wb_desc.total_byte_count != 10'h0;
    endsequence
    chk_ss_timing: assert property (ss_req |-> $past(uframe_tick) && !st[1] &&
        wb_desc.start_split_mask[$past(uframe_index)]) else $error("start-split misplaced");
    chk_cs_timing: assert property (cs_req |-> $past(uframe_tick) && st[1] &&
        wb_desc.complete_split_mask[$past(uframe_index)]) else $error("complete-split misplaced");
    chk_cs_progress: assert property (cs_req |->
        wb_desc.complete_split_progress_mask[$past(uframe_index)]) else $error("progress unset");
    chk_wb_inactive: assert property (wb_valid |-> !st[7])
        else $error("active at write-back");
    chk_fault_flags: assert property (pend && res_valid |=> (st[6:3] &
        $past(res[3:0])) == $past(res[3:0])) else $error("fault flag lost");
    chk_missed_frame: assert property (pend_cs && uframe_tick && !res_valid |=> st[2])
        else $error("missed microframe unflagged");
    chk_mem_addr: assert property (take_s ##0 !mem_valid |=> mem_valid &&
        mem_addr == $past(sel)) else $error("memory address wrong");
    chk_offset_step: assert property (take_s |=> wb_desc.current_buffer_offset ==
        $past(wb_desc.current_buffer_offset) + 12'h1) else $error("offset not advanced");
    chk_mem_hold: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr))
        else $error("memory word dropped");
endmodule : sid_props

bind sid_engine sid_props u_sid_props (.clk, .nrst, .uframe_tick, .uframe_index, .ss_req,
    .cs_req, .res_valid, .res, .in_valid, .in_ready, .wb_desc, .wb_valid, .mem_valid,
    .mem_addr, .mem_ready);

// file: bench/sid_tt_model.sv
// Translator stand-in: answers each split after a set delay.
// Assumes the bench sets answer and delay before each split.
module sid_tt_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Split side
    input wire logic ss_req,
    input wire logic cs_req,
    input wire sid_pkg::sid_res_s answer,
    input wire logic [31:0] dly,
    output logic res_valid,
    output sid_pkg::sid_res_s res
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    logic fire;
    always @(posedge clk or negedge nrst)
        if (!nrst)
        begin
            cnt = 0;
            res_valid <= 1'b0;
            res <= '0;
        end
        else
        begin
            fire = 1'b0;
            if (ss_req || cs_req)
                cnt = dly;
            else if (cnt > 0)
            begin
                cnt--;
                fire = (cnt == 0);
            end
            res_valid <= fire;
            // Flags churn while idle so a stale answer is never reused
            res <= fire ? answer : ~res;
        end
endmodule : sid_tt_model

// file: bench/sid_engine_tb.sv
// Bench for the split descriptor engine with a translator stand-in.
// Assumes the port checker binds itself to the engine.
module sid_engine_tb;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
    logic clk = 0, nrst = 0, load_valid = 0, uframe_tick = 0, in_valid = 0, mem_ready = 0;
    logic res_valid, in_ready, mem_valid, wb_valid, ss_req, cs_req, stall = 0, m_pg;
    logic [2:0] uframe_index = 3'h0;
    logic [7:0] in_data = 8'h0, mem_data;
    logic [31:0] mem_addr, r;
    logic [1:0] ss_position, exp_pos;
    logic [39:0] exp_q[$];
    sid_pkg::sid_desc_s load_desc = '0, wb_desc, d, wb_snap;
    // Write-back is a one-cycle pulse: keep its image for the checks
    logic wb_seen = 0;
    sid_pkg::sid_res_s res, answer = '0;
    int dly = 2, errors = 0, cmp_count = 0, seed = 96, cyc = 0, ss_n = 0, m_off, m_cnt, i, k;
    sid_engine u_sid_engine (.clk, .nrst, .load_valid, .load_desc, .wb_desc, .wb_valid,
        .uframe_tick, .uframe_index, .ss_req, .cs_req, .ss_position, .res_valid, .res,
        .in_valid, .in_data, .in_ready, .mem_valid, .mem_addr, .mem_data, .mem_ready);
    sid_tt_model u_sid_tt_model (.clk, .nrst, .ss_req, .cs_req, .answer, .dly, .res_valid,
        .res);
    initial forever #25 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            give_verdict();
        end
        r = $random(seed);
        mem_ready <= !stall && r[0];
        if (nrst && mem_valid && mem_ready)
            `CHK({mem_addr, mem_data}, exp_q.pop_front())
        if (ss_req)
        begin
            ss_n++;
            `CHK(ss_position, exp_pos)
        end
        if (wb_valid)
        begin
            wb_seen = 1'b1;
            wb_snap = wb_desc;
        end
    end
    task automatic give_verdict();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    task automatic load();
        load_desc <= d;
        load_valid <= 1'b1;
        m_off = d.current_buffer_offset;
        m_cnt = d.total_byte_count;
        m_pg = d.page_select;
        @(posedge clk);
        load_valid <= 1'b0;
        @(posedge clk);
    endtask : load
    task automatic send(input int n);
        repeat (n)
        begin
            in_data <= 8'($random(seed));
            in_valid <= 1'b1;
            do @(posedge clk); while (!in_ready);
            exp_q.push_back({m_pg ? d.buffer_page_pointer1 : d.buffer_page_pointer0,
                m_off[11:0], in_data});
            m_cnt--;
            m_off++;
            if (m_off == 4096)
            begin
                m_off = 0;
                m_pg = 1'b1;
            end
        end
        in_valid <= 1'b0;
    endtask : send
    task automatic tick(input logic [2:0] idx);
        uframe_tick <= 1'b1;
        uframe_index <= idx;
        @(posedge clk);
        uframe_tick <= 1'b0;
        repeat (14) @(posedge clk);
    endtask : tick
    task automatic finish(input logic [7:0] st, input logic [7:0] prog);
        for (i = 0; i < 300 && !wb_seen; i++)
            @(posedge clk);
        `CHK(wb_seen, 1'b1)
        `CHK(wb_snap.descriptor_status_byte & 8'hfc, st)
        `CHK(wb_snap.complete_split_progress_mask, prog)
        `CHK(wb_snap.current_buffer_offset, m_off[11:0])
        `CHK(wb_snap.total_byte_count, m_cnt[9:0])
        wb_seen = 1'b0;
        @(posedge clk);
    endtask : finish
    initial
    begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        // Three-part OUT payload across a page end, memory stalled at first
        d = '0;
        d.start_split_mask = 8'h07;
        d.total_byte_count = 10'h6;
        d.descriptor_status_byte = 8'h80;
        d.buffer_page_pointer0 = 20'h12345;
        d.buffer_page_pointer1 = 20'habcde;
        d.current_buffer_offset = 12'hffd;
        d.transaction_position = sid_pkg::TPOS_BEGIN;
        d.start_split_count = 3'h3;
        answer = 6'h20;
        stall = 1'b1;
        load();
        send(2);
        repeat (3) @(posedge clk);
        `CHK(in_ready, 1'b0)
        stall = 1'b0;
        send(4);
        for (k = 0; k < 3; k++)
        begin
            exp_pos = 2'(k + 1);
            tick(3'(k));
        end
        finish(8'h00, 8'h00);
        `CHK(wb_snap.start_split_count, 3'h0)
        // Whole payload answered cleanly, then once with each fault
        d.start_split_mask = 8'h01;
        d.start_split_count = 3'h1;
        d.transaction_position = sid_pkg::TPOS_ALL;
        d.total_byte_count = 10'h0;
        exp_pos = sid_pkg::TPOS_ALL;
        for (k = 0; k < 5; k++)
        begin
            answer = {k == 0, 1'b1, 4'(k ? 8 >> (k - 1) : 0)};
            load();
            tick(3'h0);
            finish(k ? 8'h80 >> k : 8'h00, 8'h00);
        end
        // An inactive descriptor is dropped
        d.descriptor_status_byte = 8'h00;
        load();
        k = ss_n;
        tick(3'h0);
        `CHK(ss_n, k)
        // IN transfer, start-split, an unmasked microframe, then two complete-splits
        d.dir_in = 1'b1;
        d.descriptor_status_byte = 8'h80;
        d.complete_split_mask = 8'h0c;
        d.total_byte_count = 10'h4;
        d.current_buffer_offset = 12'h010;
        answer = 6'h20;
        load();
        tick(3'h0);
        tick(3'h1);
        send(4);
        tick(3'h2);
        answer = 6'h30;
        tick(3'h3);
        finish(8'h00, 8'h0c);
        // Complete-split still unanswered when the next masked microframe opens
        answer = 6'h20;
        load();
        tick(3'h0);
        dly = 40;
        tick(3'h2);
        tick(3'h3);
        finish(8'h04, 8'h04);
        give_verdict();
    end
endmodule : sid_engine_tb
